// ==== keyed_watchdog_timer.sv ====
/*
 * keyed watchdog: control/status register, key sequences, lock,
 * timeout actions, event status with mask and one interrupt line.
 * assumes a register master that never overlaps read and write strobes
 * and takes read data in the cycle after the read strobe.
 */
`timescale 1ns/1ps

module keyed_watchdog_timer #(
    parameter int RESET_HOLD = wdt_pkg::RESET_HOLD
) (
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [15:0] rdata_out,
    output logic             nmi_out,
    output logic             internal_reset_out,
    output logic             system_reset_output_out,
    output logic             irq_out
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                            watchdog_on;
        logic                            timeout_reset_select;
        logic                            reset_event_flag;
        logic                            interrupt_event_flag;
        logic                            reset_output_enable;
        logic [7:0]                      exponent_select;
        logic                            locked;
        logic                            clear_armed;
        logic                            unlock_armed;
        logic                            write_open;
        logic                            in_reset;
        logic [wdt_pkg::RESET_CNT_W-1:0] reset_cnt;
        logic                            nmi;
        logic [wdt_pkg::EVT_W-1:0]       status;
        logic [wdt_pkg::EVT_W-1:0]       mask;
        logic [15:0]                     rdata;
    } wdt_state_t;

    wdt_state_t                state;
    wdt_state_t                next_state;
    logic                      count_clear;
    logic                      count_run;
    logic                      expired;
    logic                      hit_control;
    logic                      hit_status;
    logic                      hit_mask;
    logic [15:0]               control_view;
    logic [wdt_pkg::EVT_W-1:0] events;

    localparam logic [wdt_pkg::RESET_CNT_W-1:0] RESET_LAST =
        wdt_pkg::RESET_CNT_W'(RESET_HOLD - 1);

    // ------------------------------------------------------------------
    // timeout counter
    // ------------------------------------------------------------------
    timeout_counter #(
        .COUNT_W (wdt_pkg::COUNT_W)
    ) u_counter (
        .clk_in             (clk_in),
        .arst_n_in          (arst_n_in),
        .run_in             (count_run),
        .clear_in           (count_clear),
        .exponent_select_in (state.exponent_select),
        .expired_out        (expired)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_state   = state;
        count_clear  = 1'b0;
        events       = '0;
        next_state.nmi = 1'b0;

        hit_control  = (addr_in == wdt_pkg::CONTROL_OFFSET);
        hit_status   = (addr_in == wdt_pkg::STATUS_OFFSET);
        hit_mask     = (addr_in == wdt_pkg::MASK_OFFSET);

        // count is deliberately absent from this view
        control_view = '0;
        control_view[wdt_pkg::ON_BIT]       = state.watchdog_on;
        control_view[wdt_pkg::RST_SEL_BIT]  = state.timeout_reset_select;
        control_view[wdt_pkg::RST_FLAG_BIT] = state.reset_event_flag;
        control_view[wdt_pkg::IRQ_FLAG_BIT] = state.interrupt_event_flag;
        control_view[wdt_pkg::OUT_EN_BIT]   = state.reset_output_enable;
        control_view[wdt_pkg::ES_LSB +: wdt_pkg::ES_W] = state.exponent_select;
        // reserved 11-9 stay zero whatever software wrote

        count_run = state.watchdog_on && !state.in_reset;

        // --------------------------------------------------------------
        // register reads: data one cycle later, unmapped reads zero
        // --------------------------------------------------------------
        next_state.rdata = '0;
        if (rd_in) begin
            if (hit_control) begin
                next_state.rdata = control_view;
                // a read of the control register breaks any half sequence
                next_state.clear_armed  = 1'b0;
                next_state.unlock_armed = 1'b0;
            end else if (hit_status) begin
                next_state.rdata = {14'h0000, state.status};
            end else if (hit_mask) begin
                next_state.rdata = {14'h0000, state.mask};
            end
        end

        // --------------------------------------------------------------
        // register writes and key sequences
        // --------------------------------------------------------------
        // cycles at other addresses leave all arming untouched
        if (wr_in && hit_control && !state.in_reset) begin
            next_state.clear_armed  = 1'b0;
            next_state.unlock_armed = 1'b0;
            if (state.write_open) begin
                // exactly one data write per unlock
                next_state.write_open = 1'b0;
                // flags are write-zero-to-clear, also when locked
                if (!wdata_in[wdt_pkg::RST_FLAG_BIT]) begin
                    next_state.reset_event_flag = 1'b0;
                end
                if (!wdata_in[wdt_pkg::IRQ_FLAG_BIT]) begin
                    next_state.interrupt_event_flag = 1'b0;
                end
                if (!state.locked) begin
                    // repeatable while enable is kept clear
                    next_state.watchdog_on          = wdata_in[wdt_pkg::ON_BIT];
                    next_state.timeout_reset_select = wdata_in[wdt_pkg::RST_SEL_BIT];
                    next_state.reset_output_enable  = wdata_in[wdt_pkg::OUT_EN_BIT];
                    next_state.exponent_select      =
                        wdata_in[wdt_pkg::ES_LSB +: wdt_pkg::ES_W];
                    if (wdata_in[wdt_pkg::ON_BIT]) begin
                        next_state.locked = 1'b1;
                        count_clear       = 1'b1;
                    end
                end
            end else if (wdata_in == wdt_pkg::CLEAR_KEY_1) begin
                next_state.clear_armed = 1'b1;
            end else if (wdata_in == wdt_pkg::CLEAR_KEY_2 && state.clear_armed) begin
                count_clear = 1'b1;
            end else if (wdata_in == wdt_pkg::UNLOCK_KEY_1) begin
                next_state.unlock_armed = 1'b1;
            end else if (wdata_in == wdt_pkg::UNLOCK_KEY_2 && state.unlock_armed) begin
                next_state.write_open = 1'b1;
            end
            // any other word is dropped and disarms both sequences
        end

        // --------------------------------------------------------------
        // timeout actions
        // --------------------------------------------------------------
        if (expired && !count_clear) begin
            if (state.timeout_reset_select || state.interrupt_event_flag) begin
                // second timeout with the flag pending forces reset
                next_state.in_reset  = 1'b1;
                next_state.reset_cnt = '0;
            end else begin
                next_state.nmi                  = 1'b1;
                next_state.interrupt_event_flag = 1'b1;
                events[wdt_pkg::EVT_NMI_BIT]    = 1'b1;
            end
        end

        // --------------------------------------------------------------
        // watchdog reset sequence
        // --------------------------------------------------------------
        // an external reset here loads all reset values via the async path
        if (state.in_reset) begin
            count_clear = 1'b1;
            if (state.reset_cnt == RESET_LAST) begin
                next_state.in_reset             = 1'b0;
                next_state.reset_cnt            = '0;
                next_state.watchdog_on          = 1'b1;
                next_state.timeout_reset_select = 1'b1;
                next_state.exponent_select      = wdt_pkg::ES_RESET;
                next_state.reset_event_flag     = 1'b1;
                next_state.interrupt_event_flag = 1'b0;
                // output enable survives a watchdog reset
                next_state.locked               = 1'b0;
                next_state.clear_armed          = 1'b0;
                next_state.unlock_armed         = 1'b0;
                next_state.write_open           = 1'b0;
                events[wdt_pkg::EVT_RESET_BIT]  = 1'b1;
            end else begin
                next_state.reset_cnt = state.reset_cnt + wdt_pkg::RESET_CNT_W'(1);
            end
        end

        // --------------------------------------------------------------
        // event status and mask
        // --------------------------------------------------------------
        if (wr_in && hit_mask) begin
            next_state.mask = wdata_in[wdt_pkg::EVT_W-1:0];
        end
        // read clears, a same-cycle event still lands
        if (rd_in && hit_status) begin
            next_state.status = events;
        end else begin
            next_state.status = state.status | events;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state                      <= '0;
            state.watchdog_on          <= wdt_pkg::CONTROL_RESET[wdt_pkg::ON_BIT];
            state.timeout_reset_select <= wdt_pkg::CONTROL_RESET[wdt_pkg::RST_SEL_BIT];
            state.reset_event_flag     <= 1'b0;
            state.reset_output_enable  <= wdt_pkg::CONTROL_RESET[wdt_pkg::OUT_EN_BIT];
            state.exponent_select      <= wdt_pkg::ES_RESET;
            state.mask                 <= wdt_pkg::MASK_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rdata_out               = state.rdata;
    assign nmi_out                 = state.nmi;
    assign internal_reset_out      = state.in_reset;
    assign system_reset_output_out = state.in_reset && state.reset_output_enable;
    assign irq_out                 = |(state.status & state.mask);

endmodule

// ==== wdt_pkg.sv ====
/*
 * constants, field layout, key words and timing counts of the keyed watchdog.
 * assumes a 40 MHz processor clock and a 16-bit register port with byte offsets.
 */
package wdt_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int          CLK_HZ          = 40_000_000;
    localparam int          COUNT_W         = 26;
    localparam int          EXP_W           = 5;
    localparam int          RESET_HOLD      = 16;
    localparam int          RESET_CNT_W     = 5;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 16;
    localparam int          DATA_W          = 16;
    localparam logic [15:0] CONTROL_OFFSET  = 16'h03E0;
    localparam logic [15:0] STATUS_OFFSET   = 16'h03E2;
    localparam logic [15:0] MASK_OFFSET     = 16'h03E4;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int          ON_BIT          = 15;
    localparam int          RST_SEL_BIT     = 14;
    localparam int          RST_FLAG_BIT    = 13;
    localparam int          IRQ_FLAG_BIT    = 12;
    localparam int          OUT_EN_BIT      = 8;
    localparam int          ES_LSB          = 0;
    localparam int          ES_W            = 8;
    localparam logic [15:0] CONTROL_RESET   = 16'hC180;
    localparam logic [7:0]  ES_RESET        = 8'h80;

    // ------------------------------------------------------------------
    // event status and mask layout
    // ------------------------------------------------------------------
    localparam int          EVT_W           = 2;
    localparam int          EVT_NMI_BIT     = 0;
    localparam int          EVT_RESET_BIT   = 1;
    localparam logic [1:0]  MASK_RESET      = 2'h0;

    // ------------------------------------------------------------------
    // key words
    // ------------------------------------------------------------------
    localparam logic [15:0] CLEAR_KEY_1     = 16'hAAAA;
    localparam logic [15:0] CLEAR_KEY_2     = 16'h5555;
    localparam logic [15:0] UNLOCK_KEY_1    = 16'h3333;
    localparam logic [15:0] UNLOCK_KEY_2    = 16'hCCCC;

    // ------------------------------------------------------------------
    // exponent per select bit, bit 0 first
    // ------------------------------------------------------------------
    localparam logic [4:0]  EXP_BIT0        = 5'h0A;
    localparam logic [4:0]  EXP_BIT1        = 5'h14;
    localparam logic [4:0]  EXP_BIT2        = 5'h15;

    // lowest set bit wins, so the shortest timeout is used
    function automatic logic [4:0] exponent_of(input logic [7:0] es);
        logic [4:0] e;
        e = 5'h00;
        for (int i = 7; i >= 0; i--) begin
            if (es[i]) begin
                if (i == 0) begin
                    e = EXP_BIT0;
                end else if (i == 1) begin
                    e = EXP_BIT1;
                end else begin
                    e = EXP_BIT2 + 5'(i - 2);
                end
            end
        end
        return e;
    endfunction

endpackage

// ==== timeout_counter.sv ====
/*
 * free counter that expires after two to the selected exponent clocks.
 * assumes clear and run come from the control logic in the same clock domain.
 */
`timescale 1ns/1ps

module timeout_counter #(
    parameter int COUNT_W = 26
) (
    input  wire logic       clk_in,
    input  wire logic       arst_n_in,
    input  wire logic       run_in,
    input  wire logic       clear_in,
    input  wire logic [7:0] exponent_select_in,
    output logic            expired_out
);

    typedef struct packed {
        logic [COUNT_W-1:0] count;
    } cnt_state_t;

    cnt_state_t         state;
    cnt_state_t         next_state;
    logic [COUNT_W-1:0] limit;
    logic               select_valid;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_state   = state;
        select_valid = |exponent_select_in;
        limit        = (COUNT_W'(1) << wdt_pkg::exponent_of(exponent_select_in))
                       - COUNT_W'(1);
        // empty select: hold the count, never expire
        expired_out  = run_in && select_valid && (state.count == limit);
        if (clear_in || expired_out) begin
            next_state.count = '0;
        end else if (run_in && select_valid) begin
            next_state.count = state.count + COUNT_W'(1);
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

endmodule

// ==== wdt_monitor.sv ====
/*
 * port checker of the keyed watchdog, bound onto keyed_watchdog_timer.
 * assumes the register map and pulse widths of the watchdog package.
 */
`timescale 1ns/1ps

module wdt_monitor #(
    parameter int RESET_HOLD = 16
) (
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    input  wire logic [15:0] rdata_out,
    input  wire logic        nmi_out,
    input  wire logic        internal_reset_out,
    input  wire logic        system_reset_output_out,
    input  wire logic        irq_out
);
    // ------------------------------------------------------------------
    // helper state
    // ------------------------------------------------------------------
    logic [7:0] hold_cnt;
    logic       saw_nmi;

    // saw_nmi drops on any control write: conservative, flag may survive it
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hold_cnt <= 8'h00;
            saw_nmi  <= 1'b0;
        end else begin
            hold_cnt <= internal_reset_out ? hold_cnt + 8'h01 : 8'h00;
            saw_nmi  <= nmi_out | (saw_nmi & !(wr_in && addr_in == 16'h03E0) & !internal_reset_out);
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    nmi_pulse_a: assert property (nmi_out |=> !nmi_out)
        else $error("nmi longer than one cycle");
    rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
        else $error("read data outside read answer");
    reserved_zero_a: assert property (rdata_out[11:9] == 3'h0)
        else $error("reserved bits read nonzero");
    sysrst_follow_a: assert property (system_reset_output_out |-> internal_reset_out)
        else $error("system reset without internal reset");
    action_excl_a: assert property (!(nmi_out && internal_reset_out))
        else $error("nmi and reset together");
    reset_hold_a: assert property ($fell(internal_reset_out) |-> hold_cnt == 8'(RESET_HOLD))
        else $error("internal reset width wrong");
    irq_fall_a: assert property ($fell(irq_out) |-> $past(rd_in || wr_in) || $past(rd_in || wr_in, 2))
        else $error("irq fell without software access");
    nmi_flag_a: assert property ($past(rd_in && addr_in == 16'h03E0 && saw_nmi) |-> rdata_out[12])
        else $error("interrupt flag missing after nmi");

    nmi_seen_c:   cover property (nmi_out);
    reset_seen_c: cover property ($rose(internal_reset_out));
    irq_seen_c:   cover property ($rose(irq_out));
endmodule

bind keyed_watchdog_timer wdt_monitor #(.RESET_HOLD(RESET_HOLD)) u_wdt_monitor (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .nmi_out(nmi_out),
    .internal_reset_out(internal_reset_out), .system_reset_output_out(system_reset_output_out),
    .irq_out(irq_out));

// ==== keyed_watchdog_timer_tb.sv ====
/*
 * self-checking testbench of keyed_watchdog_timer.
 * assumes the 2^10 select for short timeouts and a reset hold of 2 cycles.
 */
`timescale 1ns/1ps

module keyed_watchdog_timer_tb;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    localparam logic [15:0] CTRL = wdt_pkg::CONTROL_OFFSET;
    localparam logic [15:0] STAT = wdt_pkg::STATUS_OFFSET;
    localparam logic [15:0] MASK = wdt_pkg::MASK_OFFSET;
    logic        clk_in, arst_n_in, wr_in, rd_in;
    logic [15:0] addr_in, wdata_in, rdata_out;
    logic        nmi_out, internal_reset_out, system_reset_output_out, irq_out;
    int          num_errors, total_checks, cycles, n;

    keyed_watchdog_timer #(.RESET_HOLD(2)) u_keyed_watchdog_timer (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .nmi_out(nmi_out),
        .internal_reset_out(internal_reset_out),
        .system_reset_output_out(system_reset_output_out), .irq_out(irq_out));

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    // run needs about 7100 cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 12000) begin
            num_errors++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
        wr_in    <= 1'b1;
        addr_in  <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in    <= 1'b0;
        // idle edge: the next call must not re-drive the strobe in this step
        @(posedge clk_in);
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        rd_in   <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1 chk(rdata_out, exp);
        @(posedge clk_in);
    endtask
    task automatic unlock_wr(input logic [15:0] d);
        bus_wr(CTRL, wdt_pkg::UNLOCK_KEY_1);
        bus_wr(CTRL, wdt_pkg::UNLOCK_KEY_2);
        bus_wr(CTRL, d);
    endtask
    // counts cycles until the chosen action, 1200 if none came
    task automatic wait_evt(input bit want_rst, output int cnt);
        cnt = 0;
        while (cnt < 1200) begin
            @(posedge clk_in);
            cnt++;
            #1;
            if (want_rst ? internal_reset_out : nmi_out) break;
        end
    endtask
    task automatic chk_window(input int cnt);
        chk({15'h0000, cnt >= 1020 && cnt <= 1030}, 16'h0001);
    endtask
    task automatic ext_reset();
        arst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        @(posedge clk_in);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_values();
        rd_chk(CTRL, 16'hC180);
        rd_chk(STAT, 16'h0000);
        rd_chk(MASK, 16'h0000);
        rd_chk(16'h03E6, 16'h0000);
    endtask
    task automatic t_keys();
        bus_wr(CTRL, 16'h0001);
        rd_chk(CTRL, 16'hC180);
        bus_wr(CTRL, wdt_pkg::UNLOCK_KEY_1);
        bus_wr(MASK, 16'h0001);
        bus_wr(CTRL, wdt_pkg::UNLOCK_KEY_2);
        bus_wr(CTRL, 16'h0001);
        rd_chk(CTRL, 16'h0001);
        bus_wr(CTRL, 16'h4101);
        rd_chk(CTRL, 16'h0001);
        unlock_wr(16'h4101);
        rd_chk(CTRL, 16'h4101);
        rd_chk(MASK, 16'h0001);
    endtask
    task automatic t_nmi_lock();
        unlock_wr(16'h8101);
        wait_evt(1'b0, n);
        chk_window(n);
        chk({15'h0000, internal_reset_out}, 16'h0000);
        repeat (2) @(posedge clk_in);
        #1 chk({15'h0000, irq_out}, 16'h0001);
        @(posedge clk_in);
        rd_chk(CTRL, 16'h9101);
        rd_chk(STAT, 16'h0001);
        repeat (2) @(posedge clk_in);
        #1 chk({15'h0000, irq_out}, 16'h0000);
        @(posedge clk_in);
        unlock_wr(16'h0000);
        rd_chk(CTRL, 16'h8101);
    endtask
    task automatic t_flag_reset();
        wait_evt(1'b0, n);
        chk({15'h0000, n < 1200}, 16'h0001);
        repeat (700) @(posedge clk_in);
        bus_wr(CTRL, wdt_pkg::CLEAR_KEY_1);
        bus_wr(CTRL, wdt_pkg::CLEAR_KEY_2);
        wait_evt(1'b1, n);
        chk_window(n);
        chk({15'h0000, system_reset_output_out}, 16'h0001);
        repeat (4) @(posedge clk_in);
        rd_chk(CTRL, 16'hE180);
        rd_chk(STAT, 16'h0003);
    endtask
    task automatic t_ext_select();
        ext_reset();
        rd_chk(CTRL, 16'hC180);
        unlock_wr(16'h8081);
        wait_evt(1'b0, n);
        chk_window(n);
        // flag still set, so the next timeout is a reset
        wait_evt(1'b1, n);
        chk_window(n);
        // pin reset lands while the watchdog reset still runs
        @(posedge clk_in);
        ext_reset();
        rd_chk(CTRL, 16'hC180);
        unlock_wr(16'h8000);
        wait_evt(1'b0, n);
        chk({15'h0000, n == 1200}, 16'h0001);
    endtask

    initial begin
        arst_n_in = 1'b0;
        wr_in     = 1'b0;
        rd_in     = 1'b0;
        addr_in   = 16'h0000;
        wdata_in  = 16'h0000;
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        @(posedge clk_in);
        t_reset_values();
        t_keys();
        t_nmi_lock();
        t_flag_reset();
        t_ext_select();
        report_and_stop();
    end
endmodule
